//--- rtl/caf_pkg.sv
// Shared types and constants of the processor execution datapath.
package caf_pkg;

  // Status flag bit positions inside the status byte.
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // Values after reset.
  localparam logic [7:0] SREG_RESET = 8'h00;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [3:0] SP_RESET = 4'h0;

  // Register file places that have a fixed role.
  localparam logic [4:0] IDX_PROD_LO = 5'h00;
  localparam logic [4:0] IDX_PROD_HI = 5'h01;
  localparam logic [4:0] IDX_PTR_LO = 5'h1E;
  localparam logic [4:0] IDX_PTR_HI = 5'h1F;

  // Execution cycle counts.
  localparam logic [2:0] CYC_ALU = 3'h1;
  localparam logic [2:0] CYC_WORD = 3'h2;
  localparam logic [2:0] CYC_MUL = 3'h2;
  localparam logic [2:0] CYC_REL_JUMP = 3'h2;
  localparam logic [2:0] CYC_PTR_JUMP = 3'h2;
  localparam logic [2:0] CYC_DIR_JUMP = 3'h3;
  localparam logic [2:0] CYC_REL_CALL = 3'h3;
  localparam logic [2:0] CYC_PTR_CALL = 3'h3;
  localparam logic [2:0] CYC_DIR_CALL = 3'h4;
  localparam logic [2:0] CYC_RETURN = 3'h4;
  localparam logic [2:0] CYC_SKIP_NONE = 3'h1;
  localparam logic [2:0] CYC_SKIP_ONE = 3'h2;
  localparam logic [2:0] CYC_SKIP_TWO = 3'h3;

  // Operations the datapath executes.
  typedef enum logic [5:0] {
    op_add, op_add_carry, op_add_immediate_word, op_sub, op_subtract_immediate,
    op_subtract_with_borrow, op_subtract_imm_with_borrow, op_sub_immediate_word,
    op_and, op_and_with_constant, op_or, op_or_with_constant, op_exclusive_or,
    op_ones_invert, op_twos_complement, op_set_bits_masked, op_clear_bits_masked,
    op_increment, op_decrement, op_zero_minus_test, op_clear, op_set_all_ones,
    op_mul_unsigned, op_multiply_signed, op_multiply_signed_unsigned,
    op_frac_multiply_unsigned, op_frac_multiply_signed, op_frac_multiply_mixed,
    op_relative_jump, op_pointer_jump, op_direct_jump, op_relative_subroutine_call,
    op_pointer_subroutine_call, op_direct_call, op_return, op_interrupt_return,
    op_compare_skip_equal, op_compare, op_compare_with_carry, op_compare_immediate
  } caf_op_t;

  // One decoded instruction as handed to the datapath.
  typedef struct packed {
    caf_op_t op;          // Operation.
    logic [4:0] rd;       // Destination, or low register of a pair.
    logic [4:0] rr;       // Source register.
    logic [7:0] imm;      // Immediate constant.
    logic [15:0] addr;    // Jump target or signed relative offset.
    logic next_two_word;  // The following instruction is two words long.
  } caf_cmd_t;

  // Sequencer states, Gray coded.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01
  } caf_state_t;

endpackage : caf_pkg

//--- rtl/caf_core.sv
// Execution datapath: register file, flags, program counter and return stack.
//
// What this block does
// - Add registers, optional carry, one cycle, ZCNVH.
// - Add immediate to register pair, two cycles.
// - Subtract immediate from register pair, two cycles.
// - Subtract register or constant, one cycle, ZCNVH.
// - Subtract with borrow uses carry, one cycle.
// - AND touches only Z, N, V, S.
// - OR touches only Z, N, V, S.
// - Bit clear ANDs with 0xFF minus constant.
// - Bit set ORs constant, one cycle.
// - Test ANDs register with itself, unchanged.
// - Multiplies put product in R1:R0, ZC.
// - Fractional multiplies shift product left once.
// - Pointer jump loads PC from Z, two cycles.
// - Pointer call pushes return, loads Z, three.
// - Compare skip equal advances PC 1, 2 or 3.
// - Register compares set flags, write nothing.
// - Immediate compare sets flags, discards result.
`timescale 1ns/1ns
module caf_core import caf_pkg::*; (
  input wire logic ref_clk,          // Core clock, 10 MHz.
  input wire logic sys_rst,          // Synchronous reset, active high.
  input wire logic cmd_valid,        // An instruction is offered.
  input wire caf_cmd_t cmd,          // The offered instruction.
  output logic cmd_ready,            // Datapath takes an instruction this cycle.
  output logic done,                 // One-cycle pulse when an instruction retires.
  output logic [15:0] pc,            // Program counter.
  output logic [7:0] sreg,           // Status flags.
  input wire logic ld_valid,         // Preload write into the register file.
  input wire logic [4:0] ld_idx,     // Preload register index.
  input wire logic [7:0] ld_data,    // Preload data.
  input wire logic [4:0] peek_idx,   // Register to observe.
  output logic [7:0] peek_data       // Observed register, one cycle late.
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage and sequencer state.
  logic [7:0] rf [32];
  logic [15:0] stk [16];
  logic [3:0] sp;
  caf_state_t state;
  logic [2:0] cnt;
  caf_cmd_t cur;
  logic [7:0] cap_a;
  logic [7:0] cap_b;
  logic [7:0] cap_hi;
  logic [15:0] cap_z;
  logic accept;
  logic fire;
  logic [2:0] next_cycles;
  logic next_equal;

  assign accept = cmd_valid && cmd_ready;
  assign fire = (state == ST_EXEC) && (cnt == 3'h0);
  assign next_equal = rf[cmd.rd] == rf[cmd.rr];

  // Cycle count per operation, fixed when the instruction is taken.
  always_comb begin
    unique case (cmd.op)
      op_add_immediate_word, op_sub_immediate_word: next_cycles = CYC_WORD;
      op_mul_unsigned, op_multiply_signed, op_multiply_signed_unsigned,
      op_frac_multiply_unsigned, op_frac_multiply_signed, op_frac_multiply_mixed:
        next_cycles = CYC_MUL;
      op_relative_jump: next_cycles = CYC_REL_JUMP;
      op_pointer_jump: next_cycles = CYC_PTR_JUMP;
      op_direct_jump: next_cycles = CYC_DIR_JUMP;
      op_relative_subroutine_call: next_cycles = CYC_REL_CALL;
      op_pointer_subroutine_call: next_cycles = CYC_PTR_CALL;
      op_direct_call: next_cycles = CYC_DIR_CALL;
      op_return, op_interrupt_return: next_cycles = CYC_RETURN;
      op_compare_skip_equal: begin
        // Skipping a two-word instruction costs one more fetch.
        if (next_equal) begin
          next_cycles = cmd.next_two_word ? CYC_SKIP_TWO : CYC_SKIP_ONE;
        end else begin
          next_cycles = CYC_SKIP_NONE;
        end
      end
      default: next_cycles = CYC_ALU;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: take, count down, retire.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      cnt <= 3'h0;
      cmd_ready <= 1'b0;
      done <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          done <= 1'b0;
          if (accept) begin
            state <= ST_EXEC;
            cnt <= next_cycles - 3'h1;
            cmd_ready <= 1'b0;
          end else begin
            cmd_ready <= 1'b1;
          end
        end
        ST_EXEC: begin
          if (cnt == 3'h0) begin
            state <= ST_IDLE;
            done <= 1'b1;
            cmd_ready <= 1'b1;
          end else begin
            cnt <= cnt - 3'h1;
          end
        end
      endcase
    end
  end

  // Operands are latched when taken; the file cannot change during execution.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cur <= '0;
      cap_a <= 8'h00;
      cap_b <= 8'h00;
      cap_hi <= 8'h00;
      cap_z <= 16'h0000;
    end else if (accept) begin
      cur <= cmd;
      cap_a <= rf[cmd.rd];
      cap_b <= rf[cmd.rr];
      cap_hi <= rf[5'(cmd.rd + 5'h01)];
      cap_z <= {rf[IDX_PTR_HI], rf[IDX_PTR_LO]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result and flag computation for the retiring instruction.
  logic wr_lo;
  logic wr_hi;
  logic [4:0] wr_lo_idx;
  logic [4:0] wr_hi_idx;
  logic [7:0] res_lo;
  logic [7:0] res_hi;
  logic [7:0] next_sreg;
  logic [15:0] next_pc;
  logic push;
  logic pop;

  always_comb begin
    logic [7:0] b;
    logic [7:0] av;
    logic cin;
    logic [8:0] s9;
    logic [7:0] r;
    logic [15:0] w;
    logic [8:0] ax;
    logic [8:0] bx;
    logic [17:0] prod;
    logic is_add;
    logic is_sub;
    logic is_logic;
    logic write_r;
    b = 8'h00;
    av = cap_a;
    cin = 1'b0;
    s9 = 9'h000;
    r = 8'h00;
    w = 16'h0000;
    ax = 9'h000;
    bx = 9'h000;
    prod = 18'h00000;
    is_add = 1'b0;
    is_sub = 1'b0;
    is_logic = 1'b0;
    write_r = 1'b0;
    wr_lo = 1'b0;
    wr_hi = 1'b0;
    wr_lo_idx = cur.rd;
    wr_hi_idx = 5'(cur.rd + 5'h01);
    res_lo = 8'h00;
    res_hi = 8'h00;
    next_sreg = sreg;
    next_pc = 16'(pc + 16'h0001);
    push = 1'b0;
    pop = 1'b0;
    unique case (cur.op)
      op_add, op_add_carry: begin
        cin = (cur.op == op_add_carry) & sreg[FLAG_C];
        s9 = {1'b0, cap_a} + {1'b0, cap_b} + {8'h00, cin};
        r = s9[7:0];
        is_add = 1'b1;
        write_r = 1'b1;
      end
      op_sub, op_subtract_immediate, op_subtract_with_borrow, op_subtract_imm_with_borrow,
      op_compare, op_compare_with_carry, op_compare_immediate, op_twos_complement: begin
        b = (cur.op == op_subtract_immediate || cur.op == op_subtract_imm_with_borrow ||
             cur.op == op_compare_immediate) ? cur.imm : cap_b;
        cin = (cur.op == op_subtract_with_borrow || cur.op == op_subtract_imm_with_borrow ||
               cur.op == op_compare_with_carry) & sreg[FLAG_C];
        // Negation is zero minus the operand, so zero is also the minuend seen by H and V.
        if (cur.op == op_twos_complement) begin
          av = 8'h00;
          b = cap_a;
        end
        s9 = {1'b0, av} - {1'b0, b} - {8'h00, cin};
        r = s9[7:0];
        is_sub = 1'b1;
        // Compares only set flags; the difference is dropped.
        write_r = !(cur.op == op_compare || cur.op == op_compare_with_carry ||
                    cur.op == op_compare_immediate);
      end
      op_and, op_and_with_constant, op_zero_minus_test: begin
        r = cap_a & ((cur.op == op_and_with_constant) ? cur.imm :
                     (cur.op == op_zero_minus_test) ? cap_a : cap_b);
        is_logic = 1'b1;
        write_r = 1'b1;
      end
      op_clear_bits_masked: begin
        r = cap_a & (8'hFF - cur.imm);
        is_logic = 1'b1;
        write_r = 1'b1;
      end
      op_or, op_or_with_constant, op_set_bits_masked: begin
        r = cap_a | ((cur.op == op_or) ? cap_b : cur.imm);
        is_logic = 1'b1;
        write_r = 1'b1;
      end
      op_exclusive_or, op_clear: begin
        r = cap_a ^ ((cur.op == op_clear) ? cap_a : cap_b);
        is_logic = 1'b1;
        write_r = 1'b1;
      end
      op_ones_invert: begin
        r = 8'hFF - cap_a;
        is_logic = 1'b1;
        write_r = 1'b1;
        next_sreg[FLAG_C] = 1'b1;
      end
      op_increment, op_decrement: begin
        r = (cur.op == op_increment) ? 8'(cap_a + 8'h01) : 8'(cap_a - 8'h01);
        write_r = 1'b1;
        next_sreg[FLAG_V] = (cur.op == op_increment) ? (r == 8'h80) : (r == 8'h7F);
        next_sreg[FLAG_N] = r[7];
        next_sreg[FLAG_Z] = r == 8'h00;
        next_sreg[FLAG_S] = r[7] ^ next_sreg[FLAG_V];
      end
      op_set_all_ones: begin
        r = 8'hFF;
        write_r = 1'b1;
      end
      op_add_immediate_word, op_sub_immediate_word: begin
        if (cur.op == op_add_immediate_word) begin
          w = 16'({cap_hi, cap_a} + {8'h00, cur.imm});
          next_sreg[FLAG_V] = ~cap_hi[7] & w[15];
          next_sreg[FLAG_C] = cap_hi[7] & ~w[15];
        end else begin
          w = 16'({cap_hi, cap_a} - {8'h00, cur.imm});
          next_sreg[FLAG_V] = cap_hi[7] & ~w[15];
          next_sreg[FLAG_C] = ~cap_hi[7] & w[15];
        end
        next_sreg[FLAG_N] = w[15];
        next_sreg[FLAG_Z] = w == 16'h0000;
        next_sreg[FLAG_S] = w[15] ^ next_sreg[FLAG_V];
        wr_lo = 1'b1;
        wr_hi = 1'b1;
        res_lo = w[7:0];
        res_hi = w[15:8];
      end
      op_mul_unsigned, op_multiply_signed, op_multiply_signed_unsigned,
      op_frac_multiply_unsigned, op_frac_multiply_signed, op_frac_multiply_mixed: begin
        // Sign extension to nine bits lets one signed multiplier serve all modes.
        ax = (cur.op == op_mul_unsigned || cur.op == op_frac_multiply_unsigned) ?
             {1'b0, cap_a} : {cap_a[7], cap_a};
        bx = (cur.op == op_multiply_signed || cur.op == op_frac_multiply_signed) ?
             {cap_b[7], cap_b} : {1'b0, cap_b};
        prod = 18'($signed(ax) * $signed(bx));
        next_sreg[FLAG_C] = prod[15];
        if (cur.op == op_frac_multiply_unsigned || cur.op == op_frac_multiply_signed ||
            cur.op == op_frac_multiply_mixed) begin
          w = {prod[14:0], 1'b0};
        end else begin
          w = prod[15:0];
        end
        next_sreg[FLAG_Z] = w == 16'h0000;
        wr_lo = 1'b1;
        wr_hi = 1'b1;
        wr_lo_idx = IDX_PROD_LO;
        wr_hi_idx = IDX_PROD_HI;
        res_lo = w[7:0];
        res_hi = w[15:8];
      end
      op_relative_jump: next_pc = 16'(pc + cur.addr + 16'h0001);
      op_pointer_jump: next_pc = cap_z;
      op_direct_jump: next_pc = cur.addr;
      op_relative_subroutine_call: begin
        next_pc = 16'(pc + cur.addr + 16'h0001);
        push = 1'b1;
      end
      op_pointer_subroutine_call: begin
        next_pc = cap_z;
        push = 1'b1;
      end
      op_direct_call: begin
        next_pc = cur.addr;
        push = 1'b1;
      end
      op_return, op_interrupt_return: begin
        next_pc = stk[4'(sp - 4'h1)];
        pop = 1'b1;
        if (cur.op == op_interrupt_return) begin
          next_sreg[FLAG_I] = 1'b1;
        end
      end
      op_compare_skip_equal: begin
        if (cap_a == cap_b) begin
          next_pc = 16'(pc + (cur.next_two_word ? 16'h0003 : 16'h0002));
        end
      end
    endcase
    if (write_r) begin
      wr_lo = 1'b1;
      res_lo = r;
    end
    if (is_add || is_sub || is_logic) begin
      next_sreg[FLAG_N] = r[7];
      next_sreg[FLAG_Z] = r == 8'h00;
      next_sreg[FLAG_V] = 1'b0;
    end
    if (is_add) begin
      next_sreg[FLAG_C] = s9[8];
      next_sreg[FLAG_H] = (cap_a[3] & cap_b[3]) | (cap_b[3] & ~r[3]) | (~r[3] & cap_a[3]);
      next_sreg[FLAG_V] = (cap_a[7] & cap_b[7] & ~r[7]) | (~cap_a[7] & ~cap_b[7] & r[7]);
    end
    if (is_sub) begin
      next_sreg[FLAG_C] = s9[8];
      next_sreg[FLAG_H] = (~av[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~av[3]);
      next_sreg[FLAG_V] = (av[7] & ~b[7] & ~r[7]) | (~av[7] & b[7] & r[7]);
      if (cin || cur.op == op_subtract_with_borrow || cur.op == op_subtract_imm_with_borrow ||
          cur.op == op_compare_with_carry) begin
        // Borrow chains keep Z only if every byte so far was zero.
        next_sreg[FLAG_Z] = (r == 8'h00) & sreg[FLAG_Z];
      end
    end
    if (is_add || is_sub || is_logic) begin
      next_sreg[FLAG_S] = next_sreg[FLAG_N] ^ next_sreg[FLAG_V];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Architectural state updates.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pc <= PC_RESET;
      sreg <= SREG_RESET;
    end else if (fire) begin
      pc <= next_pc;
      sreg <= next_sreg;
    end
  end

  // Return stack. A call pushes the address of the following instruction.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sp <= SP_RESET;
    end else if (fire && push) begin
      stk[sp] <= (cur.op == op_direct_call) ? 16'(pc + 16'h0002) : 16'(pc + 16'h0001);
      sp <= 4'(sp + 4'h1);
    end else if (fire && pop) begin
      sp <= 4'(sp - 4'h1);
    end
  end

  // Register file. Preload is only honoured while idle so it never races a result.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 32; i++) begin
        rf[i] <= REG_RESET;
      end
    end else if (fire) begin
      if (wr_lo) begin
        rf[wr_lo_idx] <= res_lo;
      end
      if (wr_hi) begin
        rf[wr_hi_idx] <= res_hi;
      end
    end else if (ld_valid && state == ST_IDLE) begin
      rf[ld_idx] <= ld_data;
    end
  end

  // Observation port.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      peek_data <= REG_RESET;
    end else begin
      peek_data <= rf[peek_idx];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  property p_add_sum;
    @(posedge ref_clk) disable iff (sys_rst) done && cur.op == op_add |-> rf[cur.rd] == 8'(cap_a + cap_b);
  endproperty
  a_add_sum: assert property (p_add_sum) else $error("add result wrong");

  property p_word_timing;
    @(posedge ref_clk) disable iff (sys_rst)
      accept && cmd.op == op_add_immediate_word |-> ##1 !done ##1 !done ##1 done;
  endproperty
  a_word_timing: assert property (p_word_timing) else $error("word add timing wrong");

  property p_word_sub;
    @(posedge ref_clk) disable iff (sys_rst)
      done && cur.op == op_sub_immediate_word |-> {rf[5'(cur.rd + 5'h01)], rf[cur.rd]} == 16'({cap_hi, cap_a} - cur.imm);
  endproperty
  a_word_sub: assert property (p_word_sub) else $error("word subtract wrong");

  property p_sub_carry;
    @(posedge ref_clk) disable iff (sys_rst) done && cur.op == op_sub |-> sreg[FLAG_C] == (cap_a < cap_b);
  endproperty
  a_sub_carry: assert property (p_sub_carry) else $error("subtract borrow wrong");

  property p_and_keeps;
    @(posedge ref_clk) disable iff (sys_rst)
      done && cur.op == op_and |-> sreg[FLAG_C] == $past(sreg[FLAG_C]) && sreg[FLAG_H] == $past(sreg[FLAG_H]);
  endproperty
  a_and_keeps: assert property (p_and_keeps) else $error("and changed carry");

  property p_clear_bits;
    @(posedge ref_clk) disable iff (sys_rst) done && cur.op == op_clear_bits_masked |-> rf[cur.rd] == (cap_a & ~cur.imm);
  endproperty
  a_clear_bits: assert property (p_clear_bits) else $error("bit clear wrong");

  property p_mul_product;
    @(posedge ref_clk) disable iff (sys_rst)
      done && cur.op == op_mul_unsigned |-> {rf[IDX_PROD_HI], rf[IDX_PROD_LO]} == 16'(cap_a * cap_b);
  endproperty
  a_mul_product: assert property (p_mul_product) else $error("product wrong");

  property p_pointer_jump;
    @(posedge ref_clk) disable iff (sys_rst) accept && cmd.op == op_pointer_jump |-> ##3 done && pc == $past(cap_z);
  endproperty
  a_pointer_jump: assert property (p_pointer_jump) else $error("pointer jump wrong");

  property p_skip;
    @(posedge ref_clk) disable iff (sys_rst)
      done && cur.op == op_compare_skip_equal && cap_a == cap_b && !cur.next_two_word |-> pc == 16'($past(pc) + 16'h0002);
  endproperty
  a_skip: assert property (p_skip) else $error("skip distance wrong");

  property p_compare_keeps;
    @(posedge ref_clk) disable iff (sys_rst) done && cur.op == op_compare |-> rf[cur.rd] == cap_a;
  endproperty
  a_compare_keeps: assert property (p_compare_keeps) else $error("compare wrote a register");

endmodule : caf_core

//--- testbench/tb.sv
// Self-checking testbench of the execution datapath against a behavioural model.
`timescale 1ns/1ns
module tb import caf_pkg::*;;
  logic ref_clk, sys_rst, cmd_valid, ld_valid, cmd_ready, done;
  caf_cmd_t cmd;
  logic [15:0] pc;
  logic [7:0] sreg, ld_data, peek_data;
  logic [4:0] ld_idx, peek_idx;
  logic [31:0] seed = 32'hB1CC;
  int err_total = 0;
  int compares = 0;
  int m[32];
  int m_pc = 0;
  logic [7:0] ms = 8'h00;
  int stk[$];

  caf_core u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .done(done), .pc(pc), .sreg(sreg), .ld_valid(ld_valid), .ld_idx(ld_idx),
    .ld_data(ld_data), .peek_idx(peek_idx), .peek_data(peek_data));

  // Free-running 10 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Random source and reporting.
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("Compares %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////////////
  // Behavioural model; S is refreshed as N xor V wherever zns sets Z, N and V.
  function automatic void zns(input bit z, input bit n, input bit v);
    ms[FLAG_Z] = z;
    ms[FLAG_N] = n;
    ms[FLAG_V] = v;
    ms[FLAG_S] = n ^ v;
  endfunction : zns

  // Byte add or subtract; kz keeps Z only if it was already set, as borrow chains need.
  function automatic int arith(input int a, input int b, input int ci, input bit sb, input bit kz);
    int r;
    int h;
    r = sb ? a - b - ci : a + b + ci;
    h = sb ? (a & 15) - (b & 15) - ci : (a & 15) + (b & 15) + ci;
    ms[FLAG_C] = r[8];
    ms[FLAG_H] = h[4];
    zns((r & 255) == 0 && (!kz || ms[FLAG_Z]), r[7], sb ? a[7] != b[7] && r[7] != a[7] : a[7] == b[7] && r[7] != a[7]);
    return r & 255;
  endfunction : arith

  function automatic void lgc(input logic [4:0] rd, input int r, input bit v);
    zns(r == 0, r[7], v);
    m[rd] = r;
  endfunction : lgc

  function automatic void word(input logic [4:0] rd, input int k, input bit sb);
    int w;
    int r;
    w = m[5'(rd + 1)] * 256 + m[rd];
    r = sb ? w - k : w + k;
    ms[FLAG_C] = r[16];
    zns((r & 65535) == 0, r[15], sb ? w[15] & !r[15] : !w[15] & r[15]);
    m[rd] = r & 255;
    m[5'(rd + 1)] = (r >> 8) & 255;
  endfunction : word

  function automatic void mul(input int p, input bit fr);
    ms[FLAG_C] = p[15];
    p = fr ? (p << 1) & 65535 : p & 65535;
    ms[FLAG_Z] = p == 0;
    m[0] = p & 255;
    m[1] = (p >> 8) & 255;
  endfunction : mul

  // Applies one instruction to the model and returns its cycle count.
  function automatic int model(input caf_cmd_t c);
    int a;
    int b;
    int ci;
    int opc;
    int n;
    a = m[c.rd];
    b = m[c.rr];
    ci = ms[FLAG_C];
    opc = m_pc;
    m_pc = (opc + 1) & 65535;
    if (c.op inside {op_relative_subroutine_call, op_pointer_subroutine_call}) stk.push_back((opc + 1) & 65535);
    if (c.op == op_direct_call) stk.push_back((opc + 2) & 65535);
    case (c.op)
      op_add: m[c.rd] = arith(a, b, 0, 0, 0);
      op_add_carry: m[c.rd] = arith(a, b, ci, 0, 0);
      op_sub: m[c.rd] = arith(a, b, 0, 1, 0);
      op_subtract_immediate: m[c.rd] = arith(a, c.imm, 0, 1, 0);
      op_subtract_with_borrow: m[c.rd] = arith(a, b, ci, 1, 1);
      op_subtract_imm_with_borrow: m[c.rd] = arith(a, c.imm, ci, 1, 1);
      op_compare: void'(arith(a, b, 0, 1, 0));
      op_compare_with_carry: void'(arith(a, b, ci, 1, 1));
      op_compare_immediate: void'(arith(a, c.imm, 0, 1, 0));
      op_twos_complement: m[c.rd] = arith(0, a, 0, 1, 0);
      op_add_immediate_word: word(c.rd, c.imm, 0);
      op_sub_immediate_word: word(c.rd, c.imm, 1);
      op_and: lgc(c.rd, a & b, 0);
      op_and_with_constant: lgc(c.rd, a & c.imm, 0);
      op_or: lgc(c.rd, a | b, 0);
      op_or_with_constant: lgc(c.rd, a | c.imm, 0);
      op_set_bits_masked: lgc(c.rd, a | c.imm, 0);
      op_clear_bits_masked: lgc(c.rd, a & (255 - c.imm), 0);
      op_zero_minus_test: lgc(c.rd, a & a, 0);
      op_exclusive_or: lgc(c.rd, a ^ b, 0);
      op_clear: lgc(c.rd, 0, 0);
      op_increment: lgc(c.rd, (a + 1) & 255, a == 127);
      op_decrement: lgc(c.rd, (a - 1) & 255, a == 128);
      op_set_all_ones: m[c.rd] = 255;
      op_ones_invert: begin
        lgc(c.rd, 255 - a, 0);
        ms[FLAG_C] = 1'b1;
      end
      op_mul_unsigned: mul(a * b, 0);
      op_multiply_signed: mul($signed(a[7:0]) * $signed(b[7:0]), 0);
      op_multiply_signed_unsigned: mul($signed(a[7:0]) * $signed({1'b0, b[7:0]}), 0);
      op_frac_multiply_unsigned: mul(a * b, 1);
      op_frac_multiply_signed: mul($signed(a[7:0]) * $signed(b[7:0]), 1);
      op_frac_multiply_mixed: mul($signed(a[7:0]) * $signed({1'b0, b[7:0]}), 1);
      op_relative_jump, op_relative_subroutine_call: m_pc = (opc + c.addr + 1) & 65535;
      op_pointer_jump, op_pointer_subroutine_call: m_pc = m[31] * 256 + m[30];
      op_direct_jump, op_direct_call: m_pc = c.addr;
      op_return: m_pc = stk.pop_back();
      op_interrupt_return: begin
        m_pc = stk.pop_back();
        ms[FLAG_I] = 1'b1;
      end
      op_compare_skip_equal: if (a == b) m_pc = (opc + 2 + c.next_two_word) & 65535;
      default: ;
    endcase
    case (c.op)
      op_add_immediate_word, op_sub_immediate_word, op_mul_unsigned, op_multiply_signed,
      op_multiply_signed_unsigned, op_frac_multiply_unsigned, op_frac_multiply_signed,
      op_frac_multiply_mixed, op_relative_jump, op_pointer_jump: n = 2;
      op_direct_jump, op_relative_subroutine_call, op_pointer_subroutine_call: n = 3;
      op_direct_call, op_return, op_interrupt_return: n = 4;
      default: n = 1;
    endcase
    if (c.op == op_compare_skip_equal && a == b) n = 2 + c.next_two_word;
    return n;
  endfunction : model

  ////////////////////////////////////////////////////////////////////////////////
  // Drivers; all inputs move at the falling edge so the rising edge sees them settled.
  task automatic load(input logic [4:0] i);
    logic [31:0] r;
    r = rnd();
    ld_idx = i;
    ld_data = r[7:0];
    ld_valid = 1'b1;
    m[i] = r[7:0];
    @(negedge ref_clk);
  endtask : load

  // Flow instructions skip the peeks, so the next one is offered in the retire cycle.
  task automatic exec(input caf_cmd_t c);
    int n;
    int cnt;
    logic [4:0] ix[4];
    // A preload strobe left up by load is dropped here, so it never shares the taking edge.
    ld_valid = 1'b0;
    cmd = c;
    cmd_valid = 1'b1;
    cnt = 0;
    while (cmd_ready !== 1'b1 && cnt < 20) begin
      @(negedge ref_clk);
      cnt++;
    end
    if (cnt >= 20) begin
      err_total++;
      end_of_test();
    end
    n = model(c);
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    chk({15'h0000, cmd_ready}, 16'h0000);
    cnt = 1;
    while (done !== 1'b1 && cnt < 20) begin
      @(negedge ref_clk);
      cnt++;
    end
    if (cnt >= 20) begin
      err_total++;
      end_of_test();
    end
    chk(16'(cnt), 16'(n + 1));
    chk({15'h0000, cmd_ready}, 16'h0001);
    chk(pc, 16'(m_pc));
    chk({8'h00, sreg}, {8'h00, ms});
    ix = '{c.rd, 5'(c.rd + 1), 5'h00, 5'h01};
    if (c.op < op_relative_jump || c.op > op_compare_skip_equal) begin
      foreach (ix[i]) begin
        peek_idx = ix[i];
        @(negedge ref_clk);
        chk({8'h00, peek_data}, 16'(m[ix[i]]));
      end
    end
  endtask : exec

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, preload, then three random passes over every operation.
  initial begin
    caf_cmd_t c;
    caf_op_t o;
    logic [31:0] r;
    sys_rst = 1'b1;
    cmd_valid = 1'b0;
    cmd = '0;
    ld_valid = 1'b0;
    ld_idx = 5'h00;
    ld_data = 8'h00;
    peek_idx = 5'h00;
    repeat (6) @(negedge ref_clk);
    sys_rst = 1'b0;
    chk(pc, 16'h0000);
    chk({8'h00, sreg}, 16'h0000);
    chk({14'h0000, cmd_ready, done}, 16'h0000);
    for (int i = 0; i < 32; i++) load(5'(i));
    repeat (3) begin
      o = o.first();
      do begin
        r = rnd();
        c.op = o;
        c.rd = r[4:0];
        c.rr = r[19] ? r[4:0] : r[9:5];
        c.imm = r[17:10];
        c.next_two_word = r[18];
        c.addr = r[31:16];
        if (o inside {op_add_immediate_word, op_sub_immediate_word}) c.rd = {2'b11, r[21:20], 1'b0};
        if (r[22]) load(r[27:23]);
        exec(c);
        o = o.next();
      end while (o != o.first());
    end
    end_of_test();
  end
endmodule : tb
